/* File: hw/dmba_params.svh */
`ifndef DMBA_PARAMS_SVH
`define DMBA_PARAMS_SVH

`define DMBA_ADDR_W      12
`define DMBA_MEM_BYTES   4096
`define DMBA_ACC_SPLIT   8'h80
`define DMBA_LOW_BANK    4'h0
`define DMBA_REGS_BANK   4'hf
`define DMBA_IMPL_MASK   16'h800f
`define DMBA_BSEL_ADDR   12'hfe0
`define DMBA_BSEL_RST    4'h0
`define DMBA_AXI_AW      8
`define DMBA_REG_BANKSEL 6'h00
`define DMBA_REG_STATUS  6'h01
`define DMBA_REG_IMPL    6'h02
`define DMBA_RESP_OKAY   2'b00
`define DMBA_RESP_SLVERR 2'b10

`endif

/* File: hw/dmba_pkg.sv */
package dmba_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MOVE = 3'b010,
		ST_DONE = 3'b100
	} dmba_state_e;

	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_MOVE  = 2'h2,
		OP_LOADB = 2'h3
	} dmba_op_e;

endpackage

/* File: hw/dmba_mem_if.sv */
`timescale 1ns/10ps

interface dmba_mem_if;
	logic        rd_en;
	logic [11:0] rd_addr;
	logic        rd_ovr;
	logic [7:0]  rd_ovr_data;
	logic [7:0]  rd_data;
	logic        wr_en;
	logic [11:0] wr_addr;
	logic [7:0]  wr_data;

	modport ctl (
		output rd_en,
		output rd_addr,
		output rd_ovr,
		output rd_ovr_data,
		input  rd_data,
		output wr_en,
		output wr_addr,
		output wr_data
	);

	modport mem (
		input  rd_en,
		input  rd_addr,
		input  rd_ovr,
		input  rd_ovr_data,
		output rd_data,
		input  wr_en,
		input  wr_addr,
		input  wr_data
	);
endinterface

/* File: hw/dmba_ram.sv */
`timescale 1ns/10ps
`include "dmba_params.svh"

module dmba_ram (
	input wire logic clk,
	input wire logic rst,
	dmba_mem_if.mem  mif
);

	// Whole space is declared; unimplemented banks are never written or read.
	logic [7:0] mem_q [0:`DMBA_MEM_BYTES-1];
	logic [7:0] rd_q;

	always_ff @(posedge clk) begin
		if (mif.wr_en) begin
			mem_q[mif.wr_addr] <= mif.wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_q <= 8'h00;
		end else if (mif.rd_en) begin
			if (mif.rd_ovr) begin
				rd_q <= mif.rd_ovr_data;
			end else begin
				rd_q <= mem_q[mif.rd_addr];
			end
		end
	end

	assign mif.rd_data = rd_q;

endmodule

/* File: hw/dmba_top.sv */
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "dmba_params.svh"

// Behaviour
// - Access bank joins bank 0 low 128 bytes and bank 15 high 128 bytes.
// - One access-select bit per instruction picks bank select or access bank.
// - With the bit zero, the access bank is contiguous across both halves.
// - The access bank high half reaches the special function registers.
// - Sixteen banks of 256 bytes, in-bank offsets up to 0xff.
// - Bank select low nibble gives the top four bits of the address.
// - Bank select bits 7:4 always read zero and ignore writes.
// - Unimplemented bank reads give zero and writes are dropped.
// - Unimplemented accesses still complete so the core updates its flags.
// - Full-address move uses its own 12-bit addresses, not bank select.
// - Load-bank-literal instruction writes an immediate into bank select.
module dmba_top
	import dmba_pkg::*;
(
	input  wire logic                    CORE_CLK,
	input  wire logic                    RST,
	input  wire logic                    CORE_REQ,
	input  wire logic [1:0]              CORE_OP,
	input  wire logic                    CORE_ACCESS_SEL,
	input  wire logic [7:0]              CORE_OFFSET,
	input  wire logic [7:0]              CORE_WDATA,
	input  wire logic [7:0]              CORE_BANK_LIT,
	input  wire logic [11:0]             CORE_SRC_ADDR,
	input  wire logic [11:0]             CORE_DST_ADDR,
	output logic                         CORE_READY,
	output logic                         CORE_DONE,
	output logic [7:0]                   CORE_RDATA,
	output logic                         CORE_UNIMPL,
	output logic [11:0]                  CORE_ADDR,
	input  wire logic [`DMBA_AXI_AW-1:0] S_AXI_AWADDR,
	input  wire logic                    S_AXI_AWVALID,
	output logic                         S_AXI_AWREADY,
	input  wire logic [31:0]             S_AXI_WDATA,
	input  wire logic [3:0]              S_AXI_WSTRB,
	input  wire logic                    S_AXI_WVALID,
	output logic                         S_AXI_WREADY,
	output logic [1:0]                   S_AXI_BRESP,
	output logic                         S_AXI_BVALID,
	input  wire logic                    S_AXI_BREADY,
	input  wire logic [`DMBA_AXI_AW-1:0] S_AXI_ARADDR,
	input  wire logic                    S_AXI_ARVALID,
	output logic                         S_AXI_ARREADY,
	output logic [31:0]                  S_AXI_RDATA,
	output logic [1:0]                   S_AXI_RRESP,
	output logic                         S_AXI_RVALID,
	input  wire logic                    S_AXI_RREADY
);

	dmba_mem_if mif ();

	dmba_state_e             state_q;
	dmba_op_e                op;
	logic [3:0]              bsel_q;
	logic [11:0]             dir_addr;
	logic                    req_take;
	logic [11:0]             mv_dst_q;
	logic [11:0]             last_addr_q;
	logic                    last_access_q;
	logic                    unimpl_q;
	logic                    unimpl_evt;
	logic [15:0]             unimpl_cnt_q;
	logic                    aw_full_q;
	logic                    w_full_q;
	logic [`DMBA_AXI_AW-1:0] awaddr_q;
	logic [31:0]             wdata_q;
	logic [3:0]              wstrb_q;
	logic                    bvalid_q;
	logic [1:0]              bresp_q;
	logic                    rvalid_q;
	logic [31:0]             rdata_q;
	logic [1:0]              rresp_q;
	logic                    axi_wr_fire;
	logic                    axi_bsel_wr;
	logic                    axi_clr_cnt;

	// The access bank is used when the select bit is zero; offsets from
	// 0x80 upward continue straight into the register half of bank 15.
	function automatic logic [11:0] form_addr(
		input logic       banked,
		input logic [7:0] off,
		input logic [3:0] bank
	);
		if (banked) begin
			form_addr = {bank, off};
		end else if (off < `DMBA_ACC_SPLIT) begin
			form_addr = {`DMBA_LOW_BANK, off};
		end else begin
			form_addr = {`DMBA_REGS_BANK, off};
		end
	endfunction

	function automatic logic bank_impl(input logic [11:0] addr);
		logic [15:0] mask;
		mask = `DMBA_IMPL_MASK;
		bank_impl = mask[addr[11:8]];
	endfunction

	function automatic logic is_bsel(input logic [11:0] addr);
		is_bsel = (addr == `DMBA_BSEL_ADDR);
	endfunction

	function automatic logic rd_override(input logic [11:0] addr);
		rd_override = !bank_impl(addr) || is_bsel(addr);
	endfunction

	// Bank select is held outside the RAM, so its location is answered here.
	function automatic logic [7:0] override_data(
		input logic [11:0] addr,
		input logic [3:0]  bank
	);
		if (is_bsel(addr)) begin
			override_data = {4'h0, bank};
		end else begin
			override_data = 8'h00;
		end
	endfunction

	function automatic logic store_ok(input logic [11:0] addr);
		store_ok = bank_impl(addr) && !is_bsel(addr);
	endfunction

	function automatic logic reg_known(input logic [`DMBA_AXI_AW-1:0] a);
		reg_known = (a[7:2] == `DMBA_REG_BANKSEL) ||
		            (a[7:2] == `DMBA_REG_STATUS) ||
		            (a[7:2] == `DMBA_REG_IMPL);
	endfunction

	assign op = dmba_op_e'(CORE_OP);
	assign req_take = CORE_REQ && (state_q == ST_IDLE);
	assign dir_addr = form_addr(CORE_ACCESS_SEL, CORE_OFFSET, bsel_q);

	always_comb begin
		unimpl_evt = 1'b0;
		if (req_take) begin
			unique case (op)
				OP_READ, OP_WRITE: unimpl_evt = !bank_impl(dir_addr);
				OP_MOVE: unimpl_evt = !bank_impl(CORE_SRC_ADDR) ||
				                      !bank_impl(CORE_DST_ADDR);
				OP_LOADB: unimpl_evt = 1'b0;
			endcase
		end
	end

	always_comb begin
		mif.rd_en = 1'b0;
		mif.rd_addr = dir_addr;
		mif.rd_ovr = rd_override(dir_addr);
		mif.rd_ovr_data = override_data(dir_addr, bsel_q);
		if (req_take && op == OP_READ) begin
			mif.rd_en = 1'b1;
		end else if (req_take && op == OP_MOVE) begin
			mif.rd_en = 1'b1;
			mif.rd_addr = CORE_SRC_ADDR;
			mif.rd_ovr = rd_override(CORE_SRC_ADDR);
			mif.rd_ovr_data = override_data(CORE_SRC_ADDR, bsel_q);
		end
	end

	// The move writes in its second cycle, once the source byte is latched.
	always_comb begin
		mif.wr_en = 1'b0;
		mif.wr_addr = dir_addr;
		mif.wr_data = CORE_WDATA;
		if (state_q == ST_MOVE) begin
			mif.wr_en = store_ok(mv_dst_q);
			mif.wr_addr = mv_dst_q;
			mif.wr_data = mif.rd_data;
		end else if (req_take && op == OP_WRITE) begin
			mif.wr_en = store_ok(dir_addr);
		end
	end

	dmba_ram u_ram (
		.clk (CORE_CLK),
		.rst (RST),
		.mif (mif)
	);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (req_take && op == OP_MOVE) begin
						state_q <= ST_MOVE;
					end else if (req_take) begin
						state_q <= ST_DONE;
					end
				end
				ST_MOVE: state_q <= ST_DONE;
				ST_DONE: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			mv_dst_q <= 12'h000;
		end else if (req_take && op == OP_MOVE) begin
			mv_dst_q <= CORE_DST_ADDR;
		end
	end

	// Core instructions win over a bus write to bank select in the same
	// cycle; the bus write is then lost but still answered OKAY.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			bsel_q <= `DMBA_BSEL_RST;
		end else if (req_take && op == OP_LOADB) begin
			bsel_q <= CORE_BANK_LIT[3:0];
		end else if (req_take && op == OP_WRITE && is_bsel(dir_addr)) begin
			bsel_q <= CORE_WDATA[3:0];
		end else if (state_q == ST_MOVE && is_bsel(mv_dst_q)) begin
			bsel_q <= mif.rd_data[3:0];
		end else if (axi_bsel_wr) begin
			bsel_q <= wdata_q[3:0];
		end
	end

	// The zero data and the flag let the core set its status bits normally.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			unimpl_q <= 1'b0;
		end else if (req_take) begin
			unimpl_q <= unimpl_evt;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			last_addr_q <= 12'h000;
			last_access_q <= 1'b0;
		end else if (state_q == ST_MOVE) begin
			last_addr_q <= mv_dst_q;
		end else if (req_take && op == OP_MOVE) begin
			last_addr_q <= CORE_SRC_ADDR;
			last_access_q <= 1'b0;
		end else if (req_take && op != OP_LOADB) begin
			last_addr_q <= dir_addr;
			last_access_q <= !CORE_ACCESS_SEL;
		end
	end

	// A new event in the clearing cycle leaves the count at one.
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			unimpl_cnt_q <= 16'h0000;
		end else if (unimpl_evt) begin
			unimpl_cnt_q <= axi_clr_cnt ? 16'h0001 : unimpl_cnt_q + 16'h0001;
		end else if (axi_clr_cnt) begin
			unimpl_cnt_q <= 16'h0000;
		end
	end

	assign CORE_READY = (state_q == ST_IDLE);
	assign CORE_DONE = (state_q == ST_DONE);
	assign CORE_RDATA = mif.rd_data;
	assign CORE_UNIMPL = unimpl_q;
	assign CORE_ADDR = last_addr_q;

	assign axi_wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign axi_bsel_wr = axi_wr_fire && wstrb_q[0] &&
	                    (awaddr_q[7:2] == `DMBA_REG_BANKSEL);
	assign axi_clr_cnt = axi_wr_fire && (awaddr_q[7:2] == `DMBA_REG_STATUS);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			aw_full_q <= 1'b0;
			awaddr_q <= '0;
		end else if (axi_wr_fire) begin
			aw_full_q <= 1'b0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_full_q <= 1'b1;
			awaddr_q <= S_AXI_AWADDR;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			w_full_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (axi_wr_fire) begin
			w_full_q <= 1'b0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_full_q <= 1'b1;
			wdata_q <= S_AXI_WDATA;
			wstrb_q <= S_AXI_WSTRB;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			bvalid_q <= 1'b0;
			bresp_q <= `DMBA_RESP_OKAY;
		end else if (axi_wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= reg_known(awaddr_q) ? `DMBA_RESP_OKAY :
			                                 `DMBA_RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `DMBA_RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_q <= 1'b1;
			rresp_q <= reg_known(S_AXI_ARADDR) ? `DMBA_RESP_OKAY :
			                                     `DMBA_RESP_SLVERR;
			unique case (S_AXI_ARADDR[7:2])
				`DMBA_REG_BANKSEL: rdata_q <= {24'h000000, 4'h0, bsel_q};
				`DMBA_REG_STATUS: rdata_q <= {unimpl_cnt_q, 2'b00,
				                              last_access_q, unimpl_q,
				                              last_addr_q};
				`DMBA_REG_IMPL: rdata_q <= {16'h0000, `DMBA_IMPL_MASK};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else if (S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	assign S_AXI_AWREADY = !aw_full_q && !bvalid_q;
	assign S_AXI_WREADY = !w_full_q && !bvalid_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = !rvalid_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;

endmodule

/* File: sim/dmba_chk.sv */
`timescale 1ns/10ps
`include "dmba_params.svh"

module dmba_chk (
	input wire logic                    CORE_CLK,
	input wire logic                    RST,
	input wire logic                    CORE_REQ,
	input wire logic [1:0]              CORE_OP,
	input wire logic                    CORE_ACCESS_SEL,
	input wire logic [7:0]              CORE_OFFSET,
	input wire logic [11:0]             CORE_DST_ADDR,
	input wire logic                    CORE_READY,
	input wire logic                    CORE_DONE,
	input wire logic [7:0]              CORE_RDATA,
	input wire logic                    CORE_UNIMPL,
	input wire logic [11:0]             CORE_ADDR,
	input wire logic [`DMBA_AXI_AW-1:0] S_AXI_ARADDR,
	input wire logic                    S_AXI_RVALID,
	input wire logic [31:0]             S_AXI_RDATA
);
	localparam logic [15:0] impl_mask = `DMBA_IMPL_MASK;
	wire tk = CORE_REQ && CORE_READY;
	wire dr = tk && CORE_OP < 2'h2;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	AST_DONE_RW: assert property (
		tk && CORE_OP != 2'h2 |=> CORE_DONE ##1 !CORE_DONE)
		else $error("done pulse missing");
	AST_ACC_LOW: assert property (
		dr && !CORE_ACCESS_SEL && !CORE_OFFSET[7]
		|=> CORE_ADDR == {4'h0, $past(CORE_OFFSET)})
		else $error("access low address");
	AST_ACC_HIGH: assert property (
		dr && !CORE_ACCESS_SEL && CORE_OFFSET[7]
		|=> CORE_ADDR == {4'hf, $past(CORE_OFFSET)})
		else $error("access high address");
	AST_BANKED: assert property (
		dr && CORE_ACCESS_SEL |=> CORE_ADDR[7:0] == $past(CORE_OFFSET))
		else $error("banked offset");
	AST_UNIMPL: assert property (
		dr |=> CORE_UNIMPL == !impl_mask[CORE_ADDR[11:8]])
		else $error("unimplemented flag");
	AST_ZERO: assert property (
		tk && CORE_OP == 2'h0 |=> !CORE_UNIMPL || CORE_RDATA == 8'h00)
		else $error("unimplemented read not zero");
	AST_MOVE: assert property (
		tk && CORE_OP == 2'h2 |=> !CORE_DONE ##1
		CORE_DONE && CORE_ADDR == $past(CORE_DST_ADDR, 2))
		else $error("move address");
	AST_BSEL_HI: assert property (
		$rose(S_AXI_RVALID) && $past(S_AXI_ARADDR) == 8'h00
		|-> S_AXI_RDATA[31:4] == 28'h0)
		else $error("bank select upper bits");
	AST_IMPL: assert property (
		$rose(S_AXI_RVALID) && $past(S_AXI_ARADDR) == 8'h08
		|-> S_AXI_RDATA[15:0] == impl_mask)
		else $error("bank mask");
endmodule

bind dmba_top dmba_chk u_chk (
	.CORE_CLK, .RST, .CORE_REQ, .CORE_OP, .CORE_ACCESS_SEL, .CORE_OFFSET,
	.CORE_DST_ADDR, .CORE_READY, .CORE_DONE, .CORE_RDATA, .CORE_UNIMPL,
	.CORE_ADDR, .S_AXI_ARADDR, .S_AXI_RVALID, .S_AXI_RDATA
);

/* File: sim/dmba_core_model.sv */
`timescale 1ns/10ps

module dmba_core_model (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        go,
	input wire logic [50:0] cmd,
	input wire logic        ready,
	output logic            busy,
	output logic            req,
	output logic [50:0]     flds
);
	logic [50:0] c_q;
	logic        req_q;

	// The request and its fields hold until the block takes them.
	always_ff @(posedge clk) begin
		if (rst)
			req_q <= 1'b0;
		else if (go)
			req_q <= 1'b1;
		else if (ready)
			req_q <= 1'b0;
	end
	always_ff @(posedge clk) begin
		if (rst)
			c_q <= '0;
		else if (go)
			c_q <= cmd;
	end
	// Idle fields show the inverse, so stale values cannot pass for new.
	assign flds = req_q ? c_q : ~c_q;
	assign req = req_q;
	assign busy = go | req_q;
endmodule

/* File: sim/tb_data_memory_bank_addressing.sv */
`timescale 1ns/10ps
`include "dmba_params.svh"

module tb_data_memory_bank_addressing
	import dmba_pkg::*;
;
	typedef struct packed {
		logic [7:0]  d;
		logic        u;
		logic [11:0] a;
		logic [2:0]  m;
	} dmba_exp_s;
	logic        clk = 0, rst = 1, go = 0, req, acc, busy;
	logic        rdy, done, unimpl, awr, wrdy, bv, arr, rv;
	logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic [1:0]  op, bresp, rresp;
	logic [7:0]  off, wd, lit, rdata, f;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [11:0] src, dst, caddr;
	logic [31:0] wdat = 0, rdat, seed = 32'h4457;
	logic [50:0] cmd = '0, flds;
	logic [7:0]  mem [4096];
	logic [3:0]  bank = 4'h0;
	logic [3:0]  strb = 4'hf;
	logic [33:0] aq[$], ax;
	dmba_exp_s   q[$], ex;
	int          num_errors = 0, total_checks = 0, i;

	assign {op, acc, off, wd, lit, src, dst} = flds;
	dmba_core_model core (.clk(clk), .rst(rst), .go(go), .cmd(cmd),
		.ready(rdy), .busy(busy), .req(req), .flds(flds));
	dmba_top uut (.CORE_CLK(clk), .RST(rst), .CORE_REQ(req), .CORE_OP(op),
		.CORE_ACCESS_SEL(acc), .CORE_OFFSET(off), .CORE_WDATA(wd),
		.CORE_BANK_LIT(lit), .CORE_SRC_ADDR(src), .CORE_DST_ADDR(dst),
		.CORE_READY(rdy), .CORE_DONE(done), .CORE_RDATA(rdata),
		.CORE_UNIMPL(unimpl), .CORE_ADDR(caddr), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdat),
		.S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rready));

	function automatic logic [7:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	function automatic logic impl(input logic [11:0] ad);
		logic [15:0] m;
		m = `DMBA_IMPL_MASK;
		return m[ad[11:8]];
	endfunction
	function automatic logic [7:0] rd(input logic [11:0] ad);
		if (!impl(ad))
			return 8'h00;
		return ad == `DMBA_BSEL_ADDR ? {4'h0, bank} : mem[ad];
	endfunction
	task automatic wr(input logic [11:0] ad, input logic [7:0] v);
		if (ad == `DMBA_BSEL_ADDR)
			bank = v[3:0];
		else if (impl(ad))
			mem[ad] = v;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h, want %h", $time, g, e);
		end
	endtask

	task automatic cop(input logic [1:0] o, input logic a,
		input logic [7:0] fo, input logic [7:0] v,
		input logic [11:0] s = 0, input logic [11:0] d = 0);
		dmba_exp_s e;
		logic [11:0] ad;
		ad = a ? {bank, fo} : {fo[7] ? 4'hf : 4'h0, fo};
		e = '{rd(ad), !impl(ad), ad, 3'b111};
		if (o == OP_WRITE) begin
			e.m = 3'b011;
			wr(ad, v);
		end else if (o == OP_MOVE) begin
			e = '{rd(s), !impl(s) || !impl(d), d, 3'b111};
			wr(d, rd(s));
		end else if (o == OP_LOADB) begin
			e.m = 3'b000;
			bank = v[3:0];
		end
		q.push_back(e);
		cmd <= {o, a, fo, v, v, s, d};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		while (busy)
			@(posedge clk);
	endtask

	// No cycle count is assumed; only the watchdog ends a stuck wait.
	task automatic axw(input logic [7:0] ad, input logic [31:0] v,
		input logic [1:0] er, input logic [3:0] s = 4'hf);
		awaddr <= ad;
		wdat <= v;
		strb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awr)
				awv <= 1'b0;
			if (wrdy)
				wv <= 1'b0;
		end while (!bv);
		bready <= 1'b0;
		chk(32'(bresp), 32'(er));
		@(posedge clk);
	endtask
	task automatic axr(input logic [7:0] ad, input logic [33:0] e);
		aq.push_back(e);
		araddr <= ad;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
		end while (!rv);
		rready <= 1'b0;
		@(posedge clk);
	endtask

	always @(posedge clk) begin
		if (!rst && done === 1'b1) begin
			ex = q.pop_front();
			if (ex.m[2] && !$isunknown(ex.d))
				chk(32'(rdata), 32'(ex.d));
			if (ex.m[1])
				chk(32'(unimpl), 32'(ex.u));
			if (ex.m[0])
				chk(32'(caddr), 32'(ex.a));
		end
		if (!rst && rv === 1'b1 && rready === 1'b1) begin
			ax = aq.pop_front();
			chk(rdat, ax[31:0]);
			chk(32'(rresp), 32'(ax[33:32]));
		end
	end

	task automatic results();
		$display("checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		results();
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		axr(8'h00, {`DMBA_RESP_OKAY, 32'h0});
		axr(8'h08, {`DMBA_RESP_OKAY, 16'h0, `DMBA_IMPL_MASK});
		axw(8'h08, 32'h0, `DMBA_RESP_OKAY);
		axr(8'h08, {`DMBA_RESP_OKAY, 16'h0, `DMBA_IMPL_MASK});
		axw(8'h3c, 32'h1, `DMBA_RESP_SLVERR);
		axr(8'h3c, {`DMBA_RESP_SLVERR, 32'h0});
		$display("test registers done");
		cop(OP_WRITE, 1'b0, 8'h7f, 8'h3c);
		cop(OP_WRITE, 1'b0, 8'h80, 8'hc3);
		cop(OP_READ, 1'b0, 8'h7f, 8'h00);
		cop(OP_READ, 1'b0, 8'h80, 8'h00);
		$display("test access bank done");
		for (i = 0; i < 16; i++) begin
			cop(OP_LOADB, 1'b0, 8'h00, {4'ha, 4'(i)});
			f = xs();
			cop(OP_WRITE, 1'b1, f, xs());
			cop(OP_READ, 1'b1, f, 8'h00);
			cop(OP_READ, 1'b0, f, 8'h00);
		end
		$display("test banks done");
		cop(OP_WRITE, 1'b0, 8'he0, 8'ha5);
		cop(OP_READ, 1'b0, 8'he0, 8'h00);
		axr(8'h00, {`DMBA_RESP_OKAY, 32'h5});
		axw(8'h04, 32'h0, `DMBA_RESP_OKAY);
		cop(OP_WRITE, 1'b1, 8'h10, 8'h77);
		cop(OP_READ, 1'b1, 8'h10, 8'h00);
		axr(8'h04, {`DMBA_RESP_OKAY, 16'h2, 4'b0001, 12'h510});
		axw(8'h00, 32'hfffffff3, `DMBA_RESP_OKAY);
		bank = 4'h3;
		axr(8'h00, {`DMBA_RESP_OKAY, 32'h3});
		axw(8'h00, 32'h9, `DMBA_RESP_OKAY, 4'he);
		axr(8'h00, {`DMBA_RESP_OKAY, 32'h3});
		$display("test bank select done");
		cop(OP_MOVE, 1'b0, 8'h00, 8'h00, 12'h07f, 12'h334);
		cop(OP_READ, 1'b1, 8'h34, 8'h00);
		cop(OP_MOVE, 1'b1, 8'h00, 8'h00, 12'h500, 12'h335);
		cop(OP_READ, 1'b1, 8'h35, 8'h00);
		$display("test move done");
		repeat (10) @(posedge clk);
		chk(32'(q.size() + aq.size()), 32'h0);
		results();
	end
endmodule
